//--- hdl/psd_pkg.sv
// shared constants for the pixel shader dispatch control block
package psd_pkg;
   // dispatch sizes in subspans
   localparam logic [3:0] SPANS_8  = 4'h2;
   localparam logic [3:0] SPANS_16 = 4'h4;
   localparam logic [3:0] SPANS_32 = 4'h8;
   // selection thresholds on subspans remaining
   localparam logic [15:0] THR_32 = 16'h0007;
   localparam logic [15:0] THR_16 = 16'h0002;
   // kernel entry offsets, in 128-bit instruction units
   localparam logic [1:0] ENTRY_0 = 2'h0;
   localparam logic [1:0] ENTRY_1 = 2'h1;
   localparam logic [1:0] ENTRY_2 = 2'h2;
   // start address field positions
   localparam int IP_ENTRY_LO = 4;
   localparam int IP_ENTRY_HI = 5;
   localparam int KPTR_ALIGN  = 6;
   // header field positions
   localparam int DBG_BIT    = 31;
   localparam int CNT_W      = 24;
   localparam int SCR_LO     = 10;
   localparam int COLOR_LO   = 8;
   localparam int TAG_W      = 8;
   localparam int TBL_LO     = 5;
   localparam int MASK_W     = 16;
   // register map (byte addresses)
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_KPTR    = 8'h04;
   localparam logic [7:0] A_SCRATCH = 8'h08;
   localparam logic [7:0] A_BIND    = 8'h0c;
   localparam logic [7:0] A_SAMP    = 8'h10;
   localparam logic [7:0] A_STATUS  = 8'h14;
   localparam logic [7:0] A_COUNT   = 8'h18;
   // control register fields
   localparam int C_EN8   = 0;
   localparam int C_EN16  = 1;
   localparam int C_EN32  = 2;
   localparam int C_GRF_LO = 8;
   localparam int C_GRF_W  = 5;
   localparam int C_COL_LO = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32} psd_size_t;
endpackage

//--- hdl/psd_size_sel.sv
// dispatch size selection and kernel entry choice
`timescale 1ns/100ps
module psd_size_sel (
   input  wire logic               en8,       // eight wide enable
   input  wire logic               en16,      // sixteen wide enable
   input  wire logic               en32,      // thirty-two wide enable
   input  wire logic [15:0]        remain,    // subspans remaining
   output psd_pkg::psd_size_t      size,      // chosen size
   output logic      [3:0]         spans,     // subspans taken
   output logic      [1:0]         entry      // kernel entry offset
);
   logic multi;
   // largest allowed grouping first
   always_comb begin
      if (en32 && remain > psd_pkg::THR_32) begin
         size  = psd_pkg::SZ_32;
         spans = psd_pkg::SPANS_32;
      end else if (en16 && (remain > psd_pkg::THR_16 || !en8)) begin
         size  = psd_pkg::SZ_16;
         spans = psd_pkg::SPANS_16;
      end else begin
         size  = psd_pkg::SZ_8;
         spans = psd_pkg::SPANS_8;
      end
   end
   // entry offset from enabled set and size, valid sets only
   always_comb begin
      multi = (32'(en8) + 32'(en16) + 32'(en32)) > 32'd1;
      entry = psd_pkg::ENTRY_0;
      if (multi) begin
         case (size)
            psd_pkg::SZ_8:  entry = psd_pkg::ENTRY_0;
            psd_pkg::SZ_32: entry = psd_pkg::ENTRY_1;
            psd_pkg::SZ_16: entry = psd_pkg::ENTRY_2;
            default:        entry = psd_pkg::ENTRY_0;
         endcase
      end
   end
endmodule

//--- hdl/psd_axil.sv
// axi4-lite register slave for the dispatch control
`timescale 1ns/100ps
module psd_axil (
   input  wire logic        aclk,      // core clock
   input  wire logic        aresetn,   // sync reset, low active
   input  wire logic        ce,        // clock enable
   input  wire logic [7:0]  awaddr,    // write address
   input  wire logic        awvalid,   // write address valid
   output logic             awready,   // write address ready
   input  wire logic [31:0] wdata,     // write data
   input  wire logic [3:0]  wstrb,     // byte strobes
   input  wire logic        wvalid,    // write data valid
   output logic             wready,    // write data ready
   output logic [1:0]       bresp,     // write response
   output logic             bvalid,    // write response valid
   input  wire logic        bready,    // write response ready
   input  wire logic [7:0]  araddr,    // read address
   input  wire logic        arvalid,   // read address valid
   output logic             arready,   // read address ready
   output logic [31:0]      rdata,     // read data
   output logic [1:0]       rresp,     // read response
   output logic             rvalid,    // read valid
   input  wire logic        rready,    // read ready
   input  wire logic [31:0] status,    // block status
   input  wire logic [31:0] count,     // threads dispatched
   output logic [31:0]      ctrl_q,    // control
   output logic [31:0]      kptr_q,    // kernel pointer
   output logic [31:0]      scr_q,     // scratch pointer
   output logic [31:0]      bind_q,    // binding table pointer
   output logic [31:0]      samp_q     // sampler table pointer
);
   logic       aw_q, w_q;
   logic [7:0] wa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic        hit;
   // capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q  <= 1'b0;
         wa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         bvalid <= 1'b0;
         bresp  <= psd_pkg::RESP_OK;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_q <= 1'b1;
            wa_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_q  <= 1'b1;
            wd_q <= wdata;
            ws_q <= wstrb;
         end
         if (aw_q && w_q && !bvalid) begin
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= hit ? psd_pkg::RESP_OK : psd_pkg::RESP_ERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   logic wr_go, aw_d, w_d, bv_d, rv_d;
   // next-cycle holding state, feeds the registered ready flags
   assign wr_go = aw_q && w_q && !bvalid;
   assign aw_d  = (aw_q && !wr_go) || (awvalid && awready);
   assign w_d   = (w_q && !wr_go) || (wvalid && wready);
   assign bv_d  = wr_go || (bvalid && !bready);
   assign rv_d  = (arvalid && arready) || (rvalid && !rready);
   // ready flags from flops, low while a word is held or answered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         arready <= 1'b0;
      end else if (ce) begin
         awready <= !aw_d && !bv_d;
         wready  <= !w_d && !bv_d;
         arready <= !rv_d;
      end
   end
   assign hit = (wa_q[7:2] <= psd_pkg::A_SAMP[7:2]);
   // register writes with byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (ws_q[b]) r[b*8 +: 8] = wd_q[b*8 +: 8];
      end
      return r;
   endfunction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= psd_pkg::CTRL_RST;
         kptr_q <= 32'h0000_0000;
         scr_q  <= 32'h0000_0000;
         bind_q <= 32'h0000_0000;
         samp_q <= 32'h0000_0000;
      end else if (ce && aw_q && w_q && !bvalid) begin
         case (wa_q[7:2])
            psd_pkg::A_CTRL[7:2]:    ctrl_q <= merge(ctrl_q);
            psd_pkg::A_KPTR[7:2]:    kptr_q <= merge(kptr_q);
            psd_pkg::A_SCRATCH[7:2]: scr_q  <= merge(scr_q);
            psd_pkg::A_BIND[7:2]:    bind_q <= merge(bind_q);
            psd_pkg::A_SAMP[7:2]:    samp_q <= merge(samp_q);
            default: ;
         endcase
      end
   end
   // reads answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= psd_pkg::RESP_OK;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= psd_pkg::RESP_OK;
            case (araddr[7:2])
               psd_pkg::A_CTRL[7:2]:    rdata <= ctrl_q;
               psd_pkg::A_KPTR[7:2]:    rdata <= kptr_q;
               psd_pkg::A_SCRATCH[7:2]: rdata <= scr_q;
               psd_pkg::A_BIND[7:2]:    rdata <= bind_q;
               psd_pkg::A_SAMP[7:2]:    rdata <= samp_q;
               psd_pkg::A_STATUS[7:2]:  rdata <= status;
               psd_pkg::A_COUNT[7:2]:   rdata <= count;
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= psd_pkg::RESP_ERR;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule

//--- hdl/psd_dispatch.sv
// pixel windower thread dispatch: grouping, entry point, header words
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module psd_dispatch #(
   parameter int SPAN_W = 16                 // width of subspan count
) (
   input  wire logic          aclk,          // core clock
   input  wire logic          aresetn,       // sync reset, low active
   input  wire logic          ce,            // clock enable
   // register bus
   input  wire logic [7:0]    s_awaddr,      // write address
   input  wire logic          s_awvalid,     // write address valid
   output logic               s_awready,     // write address ready
   input  wire logic [31:0]   s_wdata,       // write data
   input  wire logic [3:0]    s_wstrb,       // byte strobes
   input  wire logic          s_wvalid,      // write data valid
   output logic               s_wready,      // write data ready
   output logic [1:0]         s_bresp,       // write response
   output logic               s_bvalid,      // write response valid
   input  wire logic          s_bready,      // write response ready
   input  wire logic [7:0]    s_araddr,      // read address
   input  wire logic          s_arvalid,     // read address valid
   output logic               s_arready,     // read address ready
   output logic [31:0]        s_rdata,       // read data
   output logic [1:0]         s_rresp,       // read response
   output logic               s_rvalid,      // read valid
   input  wire logic          s_rready,      // read ready
   // object from rasterizer
   input  wire logic          obj_valid,     // new object offered
   output logic               obj_ready,     // object taken
   input  wire logic [SPAN_W-1:0] obj_spans, // subspans in object
   input  wire logic [15:0]   obj_mask,      // lit mask, first four subspans
   input  wire logic [23:0]   obj_prim_id,   // primitive id, carried in header word seven
   input  wire logic          obj_debug,     // debug match
   input  wire logic [7:0]    obj_tag,       // thread release tag
   // thread to execution units
   output logic               thr_valid,     // thread offered
   input  wire logic          thr_ready,     // thread taken
   output logic [31:0]        thr_ip,        // instruction start address
   output logic [1:0]         thr_size,      // 0:8 1:16 2:32 pixels
   output logic [5:0]         thr_grf_start, // attribute data start register
   output logic [31:0]        thr_w0,        // header word zero
   output logic [31:0]        thr_w3,        // header word three
   output logic [31:0]        thr_w4,        // header word four
   output logic [31:0]        thr_w5,        // header word five
   output logic [31:0]        thr_w6,        // header word six
   output logic [31:0]        thr_w7         // header word seven
);
   // refuse widths the subspan counter cannot serve
   if (SPAN_W < 5 || SPAN_W > 16) begin : g_bad_span_w
      $error("SPAN_W must be 5..16");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_SEND} psd_state_t;
   psd_state_t st_q;

   logic [31:0] ctrl_q, kptr_q, scr_q, bind_q, samp_q;
   logic [SPAN_W-1:0] remain_q;
   logic [15:0] mask_q;
   logic [23:0] prim_q, cnt_q;
   logic        dbg_q;
   logic [7:0]  tag_q;
   psd_pkg::psd_size_t sel_size;
   logic [3:0]  sel_spans;
   logic [1:0]  sel_entry;
   logic [15:0] remain16;
   logic [4:0]  grf_cfg;
   logic [31:0] status;

   assign remain16 = 16'(remain_q);
   assign grf_cfg  = ctrl_q[psd_pkg::C_GRF_LO +: psd_pkg::C_GRF_W];
   assign status   = {30'h0000_0000, st_q == ST_SEND, st_q != ST_IDLE};

   // register file
   psd_axil u_regs (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .awaddr  (s_awaddr),
      .awvalid (s_awvalid),
      .awready (s_awready),
      .wdata   (s_wdata),
      .wstrb   (s_wstrb),
      .wvalid  (s_wvalid),
      .wready  (s_wready),
      .bresp   (s_bresp),
      .bvalid  (s_bvalid),
      .bready  (s_bready),
      .araddr  (s_araddr),
      .arvalid (s_arvalid),
      .arready (s_arready),
      .rdata   (s_rdata),
      .rresp   (s_rresp),
      .rvalid  (s_rvalid),
      .rready  (s_rready),
      .status  (status),
      .count   ({8'h00, cnt_q}),
      .ctrl_q  (ctrl_q),
      .kptr_q  (kptr_q),
      .scr_q   (scr_q),
      .bind_q  (bind_q),
      .samp_q  (samp_q)
   );

   // size and entry selection on remaining subspans
   psd_size_sel u_sel (
      .en8    (ctrl_q[psd_pkg::C_EN8]),
      .en16   (ctrl_q[psd_pkg::C_EN16]),
      .en32   (ctrl_q[psd_pkg::C_EN32]),
      .remain (remain16),
      .size   (sel_size),
      .spans  (sel_spans),
      .entry  (sel_entry)
   );

   // object capture and dispatch sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q      <= ST_IDLE;
         obj_ready <= 1'b0;
         remain_q  <= '0;
         mask_q    <= 16'h0000;
         prim_q    <= 24'h00_0000;
         dbg_q     <= 1'b0;
         tag_q     <= 8'h00;
         thr_valid <= 1'b0;
      end else if (ce) begin
         obj_ready <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (obj_valid && !obj_ready) begin
                  obj_ready <= 1'b1;
                  remain_q  <= obj_spans;
                  mask_q    <= obj_mask;
                  prim_q    <= obj_prim_id;
                  dbg_q     <= obj_debug;
                  tag_q     <= obj_tag;
                  st_q      <= (obj_spans == '0) ? ST_IDLE : ST_SEL;
               end
            end
            ST_SEL: begin
               thr_valid <= 1'b1;
               st_q      <= ST_SEND;
            end
            ST_SEND: begin
               if (thr_ready) begin
                  thr_valid <= 1'b0;
                  // subspans are taken in arrival order, no spatial grouping
                  if (remain16 > 16'(sel_spans)) begin
                     remain_q <= remain_q - SPAN_W'(sel_spans);
                     mask_q   <= 16'h0000;
                     st_q     <= ST_SEL;
                  end else begin
                     remain_q <= '0;
                     st_q     <= ST_IDLE;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // thread counter, one step per dispatched thread
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 24'h00_0000;
      end else if (ce && st_q == ST_SEND && thr_ready) begin
         cnt_q <= cnt_q + 24'h00_0001;
      end
   end

   // payload fields latched when a thread is offered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thr_ip        <= 32'h0000_0000;
         thr_size      <= 2'h0;
         thr_grf_start <= 6'h00;
         thr_w0        <= 32'h0000_0000;
         thr_w3        <= 32'h0000_0000;
         thr_w4        <= 32'h0000_0000;
         thr_w5        <= 32'h0000_0000;
         thr_w6        <= 32'h0000_0000;
         thr_w7        <= 32'h0000_0000;
      end else if (ce && st_q == ST_SEL) begin
         // base pointer 64-byte aligned, entry in bits 5:4
         thr_ip <= {kptr_q[31:psd_pkg::KPTR_ALIGN], 6'h00}
                   | {26'h000_0000, sel_entry, 4'h0};
         thr_size <= sel_size;
         thr_grf_start <= (sel_size == psd_pkg::SZ_32) ? {grf_cfg, 1'b0}
                                                       : {1'b0, grf_cfg};
         thr_w0 <= {mask_q, mask_q};
         thr_w3 <= {samp_q[31:psd_pkg::TBL_LO], 5'h00};
         thr_w4 <= {bind_q[31:psd_pkg::TBL_LO], 5'h00};
         thr_w5 <= {scr_q[31:psd_pkg::SCR_LO],
                    ctrl_q[psd_pkg::C_COL_LO +: 2], tag_q};
         thr_w6 <= {8'h00, cnt_q};
         thr_w7 <= {dbg_q, 7'h00, prim_q};
      end
   end
endmodule

//--- test/psd_dispatch_checker.sv
// concurrent checks on the dispatch control ports
`timescale 1ns/100ps
module psd_dispatch_checker #(
   parameter int SPAN_W = 16                 // width of subspan count
) (
   input wire logic              aclk,          // core clock
   input wire logic              aresetn,       // sync reset, low active
   input wire logic              obj_ready,     // object taken
   input wire logic [SPAN_W-1:0] obj_spans,     // subspans in object
   input wire logic              thr_valid,     // thread offered
   input wire logic              thr_ready,     // thread taken
   input wire logic [31:0]       thr_ip,        // start address
   input wire logic [1:0]        thr_size,      // thread size
   input wire logic [5:0]        thr_grf_start, // attribute start register
   input wire logic [31:0]       thr_w0,        // header word zero
   input wire logic [31:0]       thr_w6,        // header word six
   input wire logic [31:0]       thr_w7         // header word seven
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [23:0] taken_q;
   // count of threads handed over so far
   always_ff @(posedge aclk) begin
      if (!aresetn) taken_q <= 24'h0;
      else if (thr_valid && thr_ready) taken_q <= taken_q + 24'h1;
   end
   property p_hold; thr_valid && !thr_ready |=> thr_valid && $stable(thr_ip); endproperty
   a_hold: assert property (p_hold) else $error("thread dropped before taken");
   property p_size; thr_valid |-> thr_size != 2'h3; endproperty
   a_size: assert property (p_size) else $error("bad thread size");
   property p_ip; thr_valid |-> thr_ip[3:0] == 4'h0; endproperty
   a_ip: assert property (p_ip) else $error("start address low bits set");
   property p_e8; thr_valid && thr_size == 2'h0 |-> thr_ip[5:4] == 2'h0; endproperty
   a_e8: assert property (p_e8) else $error("eight wide not at entry 0");
   property p_grf; thr_valid && thr_size == 2'h2 |-> !thr_grf_start[0]; endproperty
   a_grf: assert property (p_grf) else $error("start register not doubled");
   property p_mask; thr_valid |-> thr_w0[31:16] == thr_w0[15:0]; endproperty
   a_mask: assert property (p_mask) else $error("mask copy differs");
   property p_cnt; thr_valid |-> thr_w6 == {8'h0, taken_q}; endproperty
   a_cnt: assert property (p_cnt) else $error("thread counter wrong");
   property p_w7; thr_valid |-> thr_w7[30:24] == 7'h0; endproperty
   a_w7: assert property (p_w7) else $error("word seven reserved bits set");
   property p_drop; thr_valid && thr_ready |=> !thr_valid; endproperty
   a_drop: assert property (p_drop) else $error("thread kept after taken");
   property p_obj; obj_ready && obj_spans != '0 |-> ##[1:2] thr_valid; endproperty
   a_obj: assert property (p_obj) else $error("no thread after object");
   c_32: cover property (thr_valid && thr_size == 2'h2);
   c_stall: cover property (thr_valid && !thr_ready ##1 thr_valid);
   c_empty: cover property (obj_ready && obj_spans == '0);
endmodule
bind psd_dispatch psd_dispatch_checker #(.SPAN_W(SPAN_W)) psd_dispatch_checker_inst (
   .aclk(aclk), .aresetn(aresetn), .obj_ready(obj_ready), .obj_spans(obj_spans),
   .thr_valid(thr_valid), .thr_ready(thr_ready), .thr_ip(thr_ip), .thr_size(thr_size),
   .thr_grf_start(thr_grf_start), .thr_w0(thr_w0), .thr_w6(thr_w6), .thr_w7(thr_w7));

//--- test/psd_eu_model.sv
// execution unit model taking threads after a set delay
`timescale 1ns/100ps
module psd_eu_model (
   input wire logic       aclk,      // core clock
   input wire logic       aresetn,   // sync reset, low active
   input wire logic       thr_valid, // thread offered
   input wire logic [3:0] delay,     // cycles to stall before taking, less one
   output logic           thr_ready  // thread taken
);
   logic [3:0] wait_q;
   // stall for delay plus one cycles, then take for one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || !thr_valid || thr_ready) begin
         wait_q <= 4'h0;
         thr_ready <= 1'b0;
      end else if (wait_q >= delay) thr_ready <= 1'b1;
      else wait_q <= wait_q + 4'h1;
   end
endmodule

//--- test/psd_dispatch_tb.sv
// testbench for the pixel shader dispatch control block
`timescale 1ns/100ps
module psd_dispatch_tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        obj_valid, obj_ready, obj_debug, thr_valid, thr_ready;
   logic [7:0]  awaddr, araddr, obj_tag;
   logic [31:0] wdata, rdata, thr_ip, w0, w3, w4, w5, w6, w7;
   logic [1:0]  bresp, rresp, thr_size;
   logic [5:0]  thread_general_registers;
   logic [15:0] obj_spans, obj_mask;
   logic [23:0] obj_prim;
   logic [3:0]  eu_delay;
   int          num_errors = 0, num_checks = 0, cyc = 0, nthr = 0;
   localparam logic [31:0] KPTR = 32'h0012_3440; // kernel base, jump table by software
   localparam logic [31:0] SCR  = 32'h0004_5c00;
   localparam logic [31:0] BIND = 32'h0000_1fe0;
   localparam logic [31:0] SAMP = 32'h0003_0a20;
   localparam logic [4:0]  GRFS = 5'h0b;
   localparam logic [1:0]  COL  = 2'h2;
   // core clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   psd_dispatch #(.SPAN_W(16)) psd_dispatch_inst (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .obj_valid(obj_valid),
      .obj_ready(obj_ready), .obj_spans(obj_spans), .obj_mask(obj_mask),
      .obj_prim_id(obj_prim), .obj_debug(obj_debug), .obj_tag(obj_tag),
      .thr_valid(thr_valid), .thr_ready(thr_ready), .thr_ip(thr_ip), .thr_size(thr_size),
      .thr_grf_start(thread_general_registers), .thr_w0(w0), .thr_w3(w3), .thr_w4(w4), .thr_w5(w5),
      .thr_w6(w6), .thr_w7(w7));
   psd_eu_model psd_eu_model_inst (.aclk(aclk), .aresetn(aresetn), .thr_valid(thr_valid),
      .delay(eu_delay), .thr_ready(thr_ready));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // cycle ceiling against hangs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", ed, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask
   task automatic t_regs();
      axr(psd_pkg::A_CTRL, psd_pkg::CTRL_RST, psd_pkg::RESP_OK);
      axr(psd_pkg::A_KPTR, 32'h0, psd_pkg::RESP_OK);
      axr(8'h1c, 32'h0, psd_pkg::RESP_ERR);
      axw(8'h20, 32'hffff_ffff, psd_pkg::RESP_ERR);
      axw(psd_pkg::A_STATUS, 32'h1, psd_pkg::RESP_ERR);
      axw(psd_pkg::A_KPTR, KPTR, psd_pkg::RESP_OK);
      axw(psd_pkg::A_SCRATCH, SCR, psd_pkg::RESP_OK);
      axw(psd_pkg::A_BIND, BIND, psd_pkg::RESP_OK);
      axw(psd_pkg::A_SAMP, SAMP, psd_pkg::RESP_OK);
      axr(psd_pkg::A_KPTR, KPTR, psd_pkg::RESP_OK);
      axr(psd_pkg::A_STATUS, 32'h0, psd_pkg::RESP_OK);
   endtask
   // one object through to its last thread, every thread judged
   task automatic run_obj(input logic [2:0] en, input logic [15:0] n, input logic [3:0] dl);
      logic [15:0] rem;
      logic [1:0]  sz, e;
      logic        first;
      int          k;
      axw(psd_pkg::A_CTRL, {14'h0, COL, 3'h0, GRFS, 5'h0, en}, psd_pkg::RESP_OK);
      eu_delay <= dl;
      obj_spans <= n;
      obj_mask <= {n[7:0], ~n[7:0]};
      obj_prim <= {8'h5a, n};
      obj_debug <= n[0];
      obj_tag <= n[7:0] ^ 8'h3c;
      obj_valid <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (!obj_ready && k < 50);
      obj_valid <= 1'b0;
      chk("taken", 32'h1, {31'h0, obj_ready});
      rem = n;
      first = 1'b1;
      while (rem != 16'h0) begin
         if (en[2] && rem > 16'd7) sz = 2'h2;
         else if (en[1] && (rem > 16'd2 || !en[0])) sz = 2'h1;
         else sz = 2'h0;
         e = (en == 3'h1 || en == 3'h2 || en == 3'h4 || sz == 2'h0) ? 2'h0 : sz ^ 2'h3;
         k = 0;
         do begin
            @(posedge aclk);
            k++;
         end while (!thr_valid && k < 50);
         chk("size", {30'h0, sz}, {30'h0, thr_size});
         chk("ip", {KPTR[31:6], e, 4'h0}, thr_ip);
         chk("grf", {26'h0, sz == 2'h2 ? {GRFS, 1'b0} : {1'b0, GRFS}}, {26'h0, thread_general_registers});
         chk("w0", first ? {obj_mask, obj_mask} : 32'h0, w0);
         chk("w3", SAMP, w3);
         chk("w4", BIND, w4);
         chk("w5", {SCR[31:10], COL, obj_tag}, w5);
         chk("w6", {8'h0, nthr[23:0]}, w6);
         chk("w7", {obj_debug, 7'h0, obj_prim}, w7);
         if (dl > 4'h3) axr(psd_pkg::A_STATUS, 32'h3, psd_pkg::RESP_OK); // busy, thread offered
         while (!thr_ready) @(posedge aclk);
         nthr++;
         rem = (rem > (16'h2 << sz)) ? rem - (16'h2 << sz) : 16'h0;
         first = 1'b0;
      end
      repeat (3) @(posedge aclk);
      chk("idle", 32'h0, {31'h0, thr_valid});
   endtask
   task automatic t_dispatch();
      logic [2:0]  ens [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      logic [15:0] ns [5] = '{16'h1, 16'h3, 16'h8, 16'hb, 16'h11};
      for (int i = 0; i < 5; i++) begin
         for (int j = 0; j < 5; j++) begin
            run_obj(ens[i], ns[j], 4'(i + j));
         end
      end
      run_obj(3'h7, 16'h0, 4'h0);
   endtask
   // main sequence
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, obj_valid, obj_debug} = 7'h0;
      {awaddr, araddr, obj_tag, wdata} = 56'h0;
      {obj_spans, obj_mask, obj_prim, eu_delay} = 60'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_dispatch();
      axr(psd_pkg::A_COUNT, nthr, psd_pkg::RESP_OK);
      axw(psd_pkg::A_COUNT, 32'h0, psd_pkg::RESP_ERR);
      give_verdict();
   end
endmodule
